// ==== logic/drive_safety_params.svh ====
// Timing and configuration constants for the drive safety sequencer
`ifndef DRIVE_SAFETY_PARAMS_SVH
`define DRIVE_SAFETY_PARAMS_SVH

// Clock period in picoseconds (250 MHz)
`define CLK_PERIOD_PS          4000
// Monitoring cycle in microseconds (4 ms)
`define MONITOR_CYCLE_US       4000
// Monitoring cycle in clock cycles; scaled in steps that stay inside 32-bit arithmetic
`define MONITOR_CYCLE_CLKS     ((`MONITOR_CYCLE_US * 1000) / (`CLK_PERIOD_PS / 1000))
// Telegrams are evaluated every second monitoring cycle
`define TELEGRAM_DIVIDE        2
// Width of time settings, counted in monitoring cycles
`define TIME_W                 16
// Reset value of the shutdown speed threshold field
`define SHUTDOWN_SPEED_RST     16'h0010
// Reset values of the safety delay and of both brake times
`define DELAY_RST              16'h0000
`define BRAKE_TIME_RST         16'h0001

// Avalon register byte offsets
`define REG_CONFIG             8'h00
`define REG_DELAY              8'h04
`define REG_BRAKE_TIMES        8'h08
`define REG_COMMAND            8'h0c
`define REG_STATUS             8'h10
`define REG_SPEED              8'h14

// CONFIG fields
`define CFG_BRAKE_EN_BIT       0
`define CFG_BRAKE_FITTED_BIT   1
`define CFG_EXT_BRAKING_BIT    2
// COMMAND fields
`define CMD_TORQUE_OFF_BIT     0
`define CMD_TIMED_STOP_BIT     1
`define CMD_RUN_BIT            2
`define CMD_COAST_BIT          3
`define CMD_NSTOP_BIT          4
`define CMD_FSTOP_BIT          5
`define CMD_BRAKE_OPEN_BIT     6
`define CMD_FAULT_ACK_BIT      7

`endif

// ==== logic/drive_safety_pkg.sv ====
// Types shared by the drive safety sequencer
package drive_safety_pkg;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_RUN       = 5'b00001,
    ST_TORQUE_OFF = 5'b00010,
    ST_TIMED_STOP = 5'b00100,
    ST_READY     = 5'b01000,
    ST_LOCKED    = 5'b10000
  } seq_state_e;

  // Control selections gathered per telegram scan
  typedef struct packed {
    logic torque_off_sel;
    logic timed_stop_sel;
    logic run;
    logic coast;
    logic brake_open_req;
  } select_s;

  // Status returned to the controller
  typedef struct packed {
    logic torque_off;
    logic timed_stop_active;
    logic ramp_active;
    logic brake_closed;
    logic brake_fault;
    logic motor_on;
  } status_s;

endpackage

// ==== logic/drive_safe_stop_brake_sequencer.sv ====
// Safe torque removal, safe brake control and timed safe stop sequencer
`timescale 1ns/1ps
`include "drive_safety_params.svh"

module drive_safe_stop_brake_sequencer
  import drive_safety_pkg::*;
#(
  // Monitoring cycle length in clocks; a bench may shorten it to keep runs brief
  parameter int unsigned MON_CLKS = `MONITOR_CYCLE_CLKS
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  // Fail-safe digital input, high selects the stop function
  input  wire logic        failsafe_digital_input,
  // Motor speed magnitude and brake feedback
  input  wire logic [15:0] motor_speed,
  input  wire logic        brake_feedback_ok,
  // Drive outputs
  output logic             pulse_enable,
  output logic             brake_energize,
  output logic             fast_stop_ramp,
  output logic             timed_stop_active
);

  // ==========================================================
  // Registers and timebase
  // ==========================================================
  logic [2:0]           config_bits;
  logic [`TIME_W-1:0]   safety_delay_time;
  logic [`TIME_W-1:0]   brake_closing_time;
  logic [`TIME_W-1:0]   brake_opening_time;
  logic [7:0]           command;
  logic [15:0]          shutdown_speed;
  logic [19:0]          tick_cnt;
  logic                 mon_tick;
  logic                 tel_phase;
  logic                 tel_tick;
  select_s              sel;
  logic                 fs_input_q;
  logic                 run_q;
  seq_state_e           state;
  logic [`TIME_W-1:0]   delay_cnt;
  logic                 brake_timer_closing;
  logic [`TIME_W-1:0]   brake_cnt;
  status_s              stat;
  logic                 brake_fault;
  logic                 fault_latched;
  logic                 ack_pulse;
  logic                 access;
  logic                 acked;

  // Byte-lane merge for write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Monitoring tick; everything safety-related steps on it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= 20'h00000;
      mon_tick <= 1'b0;
    end else if (tick_cnt == 20'(MON_CLKS - 1)) begin
      tick_cnt <= 20'h00000;
      mon_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 20'h00001;
      mon_tick <= 1'b0;
    end
  end

  // Telegram scan every second monitoring cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tel_phase <= 1'b0;
    end else if (mon_tick) begin
      tel_phase <= ~tel_phase;
    end
  end
  assign tel_tick = mon_tick & tel_phase;

  // ==========================================================
  // Avalon slave: one wait cycle, answer on the second edge
  // ==========================================================
  assign access = avs_read | avs_write;
  assign avs_waitrequest = access & ~acked;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acked <= 1'b0;
    end else begin
      acked <= access & ~acked;
    end
  end

  // Register writes take effect on the accepting edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      config_bits        <= 3'h0;
      safety_delay_time  <= `DELAY_RST;
      brake_closing_time <= `BRAKE_TIME_RST;
      brake_opening_time <= `BRAKE_TIME_RST;
      command            <= 8'h00;
      shutdown_speed     <= `SHUTDOWN_SPEED_RST;
      ack_pulse          <= 1'b0;
    end else begin
      ack_pulse <= 1'b0;
      if (avs_write && acked) begin
        unique case (avs_address)
          `REG_CONFIG:      config_bits <= 3'(merge({29'h0, config_bits}, avs_writedata,
                                                    avs_byteenable));
          `REG_DELAY:       safety_delay_time <= 16'(merge({16'h0, safety_delay_time},
                                                          avs_writedata, avs_byteenable));
          `REG_BRAKE_TIMES: begin
            // Both halves merge from one word so each lane lands in its own half
            brake_closing_time <= 16'(merge({brake_opening_time, brake_closing_time},
                                            avs_writedata, avs_byteenable));
            brake_opening_time <= 16'(merge({brake_opening_time, brake_closing_time},
                                            avs_writedata, avs_byteenable) >> 16);
          end
          `REG_COMMAND: begin
            command   <= 8'(merge({24'h0, command}, avs_writedata, avs_byteenable));
            ack_pulse <= avs_byteenable[0] & avs_writedata[`CMD_FAULT_ACK_BIT];
          end
          `REG_SPEED:       shutdown_speed <= 16'(merge({16'h0, shutdown_speed}, avs_writedata,
                                                       avs_byteenable));
          default: ;
        endcase
      end
    end
  end

  // Read data registered; unmapped reads answer zero with a slave error
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else if (access && !acked) begin
      avs_response <= 2'h0;
      unique case (avs_address)
        `REG_CONFIG:      avs_readdata <= {29'h0, config_bits};
        `REG_DELAY:       avs_readdata <= {16'h0, safety_delay_time};
        `REG_BRAKE_TIMES: avs_readdata <= {brake_opening_time, brake_closing_time};
        `REG_COMMAND:     avs_readdata <= {24'h0, command};
        `REG_STATUS:      avs_readdata <= {25'h0, fault_latched, stat};
        `REG_SPEED:       avs_readdata <= {16'h0, shutdown_speed};
        default: begin
          avs_readdata <= 32'h00000000;
          avs_response <= 2'h2;
        end
      endcase
    end
  end

  // ==========================================================
  // Selection sampling
  // ==========================================================
  // Telegram bits sampled per scan, the input per monitoring cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel.torque_off_sel <= 1'b0;
      sel.timed_stop_sel <= 1'b0;
      sel.run            <= 1'b0;
      sel.coast          <= 1'b0;
      sel.brake_open_req <= 1'b0;
      fs_input_q         <= 1'b0;
      run_q              <= 1'b0;
    end else begin
      if (tel_tick) begin
        sel.torque_off_sel <= command[`CMD_TORQUE_OFF_BIT];
        sel.timed_stop_sel <= command[`CMD_TIMED_STOP_BIT];
        sel.run            <= command[`CMD_RUN_BIT];
        sel.coast          <= command[`CMD_COAST_BIT];
        sel.brake_open_req <= command[`CMD_BRAKE_OPEN_BIT];
      end
      if (mon_tick) begin
        fs_input_q <= failsafe_digital_input;
        run_q <= sel.run;
      end
    end
  end

  // Either source selects; a zero delay on the input means direct torque removal
  logic torque_off_req;
  logic timed_stop_req;
  logic run_rise;
  logic delay_zero;
  assign delay_zero     = (safety_delay_time == 16'h0000);
  assign torque_off_req = sel.torque_off_sel | (fs_input_q & delay_zero);
  assign timed_stop_req = sel.timed_stop_sel | (fs_input_q & ~delay_zero);
  assign run_rise = mon_tick & sel.run & ~run_q;

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_READY;
      delay_cnt <= 16'h0000;
    end else if (mon_tick) begin
      unique case (state)
        ST_RUN, ST_READY: begin
          if (torque_off_req) begin
            state <= ST_TORQUE_OFF;
          end else if (timed_stop_req) begin
            state     <= ST_TIMED_STOP;
            delay_cnt <= safety_delay_time;
          end else if (state == ST_READY && run_rise && !sel.coast) begin
            state <= ST_RUN;
          end else if (state == ST_RUN && sel.coast) begin
            state <= ST_READY;
          end
        end
        ST_TIMED_STOP: begin
          // Stop commands do not alter the sequence; early release ends it only once motor_speed is below shutdown_speed
          if (delay_cnt <= 16'h0001 ||
              (!timed_stop_req && motor_speed < shutdown_speed)) begin
            state <= ST_TORQUE_OFF;
          end else begin
            delay_cnt <= delay_cnt - 16'h0001;
          end
        end
        ST_TORQUE_OFF: begin
          // Release acts as an internal acknowledgment once the cause is gone
          if (!torque_off_req && !timed_stop_req && !brake_fault) begin
            state <= ST_LOCKED;
          end
        end
        ST_LOCKED: begin
          // Switching-on inhibit: only a fresh run edge restarts
          if (torque_off_req) begin
            state <= ST_TORQUE_OFF;
          end else if (timed_stop_req) begin
            state     <= ST_TIMED_STOP;
            delay_cnt <= safety_delay_time;
          end else if (run_rise && !sel.coast) begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_TORQUE_OFF;
      endcase
    end
  end

  // Drive outputs; coast stop cuts pulses even inside the timed stop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pulse_enable      <= 1'b0;
      fast_stop_ramp    <= 1'b0;
      timed_stop_active <= 1'b0;
    end else begin
      pulse_enable      <= (state == ST_RUN || state == ST_TIMED_STOP) && !sel.coast;
      fast_stop_ramp    <= (state == ST_TIMED_STOP) &&
                           !config_bits[`CFG_EXT_BRAKING_BIT];
      timed_stop_active <= (state == ST_TIMED_STOP);
    end
  end

  // ==========================================================
  // Brake control
  // ==========================================================
  logic brake_safety_on;
  assign brake_safety_on = config_bits[`CFG_BRAKE_EN_BIT] &
                           config_bits[`CFG_BRAKE_FITTED_BIT];
  // Safety close request follows torque removal in the same cycle
  logic brake_close_cmd;
  assign brake_close_cmd = (brake_safety_on && state == ST_TORQUE_OFF) ||
                           brake_fault ||
                           !(state == ST_RUN && sel.brake_open_req);

  // Path check: feedback must agree with the command; fault_latched stays until acknowledged, brake_fault clears in torque off once feedback is good
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brake_fault   <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      if (mon_tick && brake_safety_on && !brake_feedback_ok) begin
        brake_fault   <= 1'b1;
        fault_latched <= 1'b1;
      end else if (ack_pulse) begin
        fault_latched <= 1'b0;
      end
      if (mon_tick && brake_feedback_ok && state == ST_TORQUE_OFF &&
          !torque_off_req && !timed_stop_req) begin
        brake_fault <= 1'b0;
      end
    end
  end

  // Output drive and closing/opening time accounting
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      brake_energize      <= 1'b0;
      brake_timer_closing <= 1'b1;
      brake_cnt           <= 16'h0000;
    end else begin
      brake_energize <= !brake_close_cmd;
      if (brake_close_cmd != brake_timer_closing) begin
        brake_timer_closing <= brake_close_cmd;
        brake_cnt <= brake_close_cmd ? brake_closing_time : brake_opening_time;
      end else if (mon_tick && brake_cnt != 16'h0000) begin
        brake_cnt <= brake_cnt - 16'h0001;
      end
    end
  end

  // Status word
  always_comb begin
    stat.torque_off        = !pulse_enable;
    stat.timed_stop_active = timed_stop_active;
    stat.ramp_active       = fast_stop_ramp;
    stat.brake_closed      = brake_timer_closing && brake_cnt == 16'h0000;
    stat.brake_fault       = brake_fault;
    stat.motor_on          = !brake_timer_closing && brake_cnt == 16'h0000 &&
                             pulse_enable;
  end

endmodule

// ==== verification/seq_monitor.sv ====
// Port-level assertions for the safety sequencer
`timescale 1ns/1ps
`include "drive_safety_params.svh"
module seq_monitor #(
  parameter int TICK = `MONITOR_CYCLE_CLKS
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        brake_feedback_ok,
  input wire logic        pulse_enable,
  input wire logic        brake_energize,
  input wire logic        fast_stop_ramp,
  input wire logic        timed_stop_active
);
  // ====================
  // Helper counters
  int gap;
  int bad;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycles since an output last moved; starts full so the first move passes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap <= TICK;
    end else if ($changed({pulse_enable, timed_stop_active, fast_stop_ramp})) begin
      gap <= 0;
    end else if (gap < TICK) begin
      gap <= gap + 1;
    end
  end
  // Cycles of bad brake feedback; saturates so it never wraps
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bad <= 0;
    end else if (brake_feedback_ok) begin
      bad <= 0;
    end else if (bad < 2 * TICK) begin
      bad <= bad + 1;
    end
  end
  // ====================
  // Properties
  property p_ramp_in_stop;
    fast_stop_ramp |-> timed_stop_active;
  endproperty
  a_ramp_in_stop: assert property (p_ramp_in_stop) else $error("ramp outside stop");
  property p_stop_end_no_torque;
    $fell(timed_stop_active) |-> !pulse_enable;
  endproperty
  a_stop_end_no_torque: assert property (p_stop_end_no_torque) else $error("torque kept");
  property p_tick_paced;
    $changed({pulse_enable, timed_stop_active, fast_stop_ramp}) |-> gap >= TICK - 1;
  endproperty
  a_tick_paced: assert property (p_tick_paced) else $error("output moved off tick");
  property p_brake_fault_cut;
    bad >= 2 * TICK |-> !brake_energize;
  endproperty
  a_brake_fault_cut: assert property (p_brake_fault_cut) else $error("brake kept open");
  property p_reset_quiet;
    $rose(resetn) |-> !(pulse_enable || brake_energize || fast_stop_ramp || timed_stop_active);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
  property p_wait_first;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait in first cycle");
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
  property p_unmapped;
    avs_read && !avs_waitrequest && (avs_address > `REG_SPEED) |-> avs_response == 2'h2;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not flagged");
  // Main scenarios reached
  c_ramp: cover property (timed_stop_active && fast_stop_ramp);
  c_cut: cover property ($fell(pulse_enable) && timed_stop_active);
  c_unmapped: cover property (avs_read && !avs_waitrequest && avs_response == 2'h2);
endmodule

bind drive_safe_stop_brake_sequencer seq_monitor #(.TICK(MON_CLKS)) i_seq_monitor (
  .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .brake_feedback_ok(brake_feedback_ok), .pulse_enable(pulse_enable),
  .brake_energize(brake_energize), .fast_stop_ramp(fast_stop_ramp),
  .timed_stop_active(timed_stop_active));

// ==== verification/plant_model.sv ====
// Controller, fail-safe input and motor model at the sequencer's far side
`timescale 1ns/1ps
module plant_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        pulse_enable,
  input  wire logic        fast_stop_ramp,
  input  wire logic        stop_sel,
  input  wire logic        ext_brake,
  input  wire logic        path_break,
  output logic             fsel_out,
  output logic      [15:0] speed,
  output logic             fb_ok
);
  logic [11:0] pre;
  // Speed moves slowly so a stop spans several monitoring ticks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre      <= 12'h000;
      speed    <= 16'h0000;
      fsel_out <= 1'b0;
      fb_ok    <= 1'b1;
    end else begin
      pre      <= pre + 12'h001;
      fsel_out <= stop_sel;
      fb_ok    <= !path_break;
      if (pre == 12'h000) begin
        // Controller brakes on its own setpoint in the external variant
        if (!pulse_enable || fast_stop_ramp || ext_brake) begin
          speed <= (speed != 16'h0000) ? speed - 16'h0001 : speed;
        end else if (speed != 16'h0200) begin
          speed <= speed + 16'h0001;
        end
      end
    end
  end
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the safety sequencer
`timescale 1ns/1ps
`include "drive_safety_params.svh"
module tb;
  // Shortened monitoring cycle so a run stays brief; handed to the design as a parameter
  localparam int TICK = 40;
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d; logic [3:0] b; logic [31:0] e; logic [1:0] r;
  } row_s;
  logic        clk, resetn, rd, wr, wreq, fsdi, fb_ok, sel, xbrk, brk;
  logic        pe, bk, ramp, tsa;
  logic [7:0]  adr;
  logic [3:0]  ben;
  logic [1:0]  rsp, grsp;
  logic [15:0] spd;
  logic [31:0] wdat, rdat, got;
  int          n_fail, total_checks, run_cyc;
  string       onames [4] = '{"pulse_enable", "brake_energize", "fast_stop_ramp", "timed_stop"};
  // Register rows: reset values, lane merge, unmapped place
  row_s rows [10] = '{
    '{1'b0, `REG_CONFIG, 32'h0, 4'hf, 32'h0, 2'h0},
    '{1'b0, `REG_DELAY, 32'h0, 4'hf, 32'h0, 2'h0},
    '{1'b0, `REG_BRAKE_TIMES, 32'h0, 4'hf, 32'h00010001, 2'h0},
    '{1'b0, `REG_SPEED, 32'h0, 4'hf, 32'(`SHUTDOWN_SPEED_RST), 2'h0},
    '{1'b1, `REG_BRAKE_TIMES, 32'h00050003, 4'hf, 32'h0, 2'h0},
    '{1'b1, `REG_BRAKE_TIMES, 32'hffff0002, 4'h1, 32'h0, 2'h0},
    '{1'b0, `REG_BRAKE_TIMES, 32'h0, 4'hf, 32'h00050002, 2'h0},
    '{1'b1, 8'h18, 32'hffffffff, 4'hf, 32'h0, 2'h0},
    '{1'b0, 8'h18, 32'h0, 4'hf, 32'h0, 2'h2},
    '{1'b1, `REG_BRAKE_TIMES, 32'h00010001, 4'hf, 32'h0, 2'h0}};

  drive_safe_stop_brake_sequencer #(.MON_CLKS(TICK)) i_drive_safe_stop_brake_sequencer (
    .clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(ben), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .avs_response(rsp), .failsafe_digital_input(fsdi),
    .motor_speed(spd), .brake_feedback_ok(fb_ok), .pulse_enable(pe),
    .brake_energize(bk), .fast_stop_ramp(ramp), .timed_stop_active(tsa));
  plant_model i_plant_model (
    .clk(clk), .resetn(resetn), .pulse_enable(pe), .fast_stop_ramp(ramp), .stop_sel(sel),
    .ext_brake(xbrk), .path_break(brk), .fsel_out(fsdi), .speed(spd), .fb_ok(fb_ok));

  // ====================
  // Clock and stop-length counter
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Counts cycles of a running timed stop; cleared only while running plainly
  always @(negedge clk) begin
    if (tsa === 1'b1 && pe === 1'b1) run_cyc++;
    else if (pe === 1'b1) run_cyc = 0;
  end

  // ====================
  // Tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until waitrequest is seen low before an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    logic ok;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    ben <= b;
    rd <= !w;
    wr <= w;
    n = 0;
    // Waitrequest and the answer are taken at the very edge that ends the request
    do begin
      @(posedge clk);
      ok = (wreq === 1'b0);
      n++;
    end while (!ok && n < 20);
    got = rdat;
    grsp = rsp;
    rd <= 1'b0;
    wr <= 1'b0;
    chk("bus answer", 1'b1, ok);
    if (!ok) end_of_test();
  endtask
  task automatic cmd(input logic [31:0] v);
    bus(1'b1, `REG_COMMAND, v, 4'hf);
  endtask
  function automatic logic outv(input int k);
    return (k == 0) ? pe : (k == 1) ? bk : (k == 2) ? ramp : tsa;
  endfunction
  // Bounded wait; a wait that runs out ends the run
  task automatic wait_for(input int k, input logic v, input int ticks);
    int n;
    n = 0;
    while (outv(k) !== v && n < ticks * TICK) begin
      @(negedge clk);
      n++;
    end
    chk(onames[k], v, outv(k));
    if (outv(k) !== v) end_of_test();
  endtask
  // Telegrams are read every second tick, so three ticks always cover one
  task automatic idle(input int ticks);
    repeat (ticks * TICK) @(negedge clk);
  endtask
  task automatic restart();
    cmd(32'h40);
    idle(3);
    cmd(32'h44);
    wait_for(0, 1'b1, 4);
    wait_for(1, 1'b1, 4);
  endtask

  // ====================
  // Main sequence
  initial begin
    {resetn, rd, wr, sel, xbrk, brk, adr, wdat, ben, n_fail, total_checks, run_cyc} = '0;
    repeat (12) @(posedge clk);
    chk("outputs in reset", 4'h0, {pe, bk, ramp, tsa});
    resetn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, rows[i].b);
      if (!rows[i].w) chk("readdata", rows[i].e, got);
      if (!rows[i].w) chk("response", rows[i].r, grsp);
    end
    // Brake control enabled and fitted; first run edge opens brake
    bus(1'b1, `REG_CONFIG, 32'h3, 4'hf);
    restart();
    // Fail-safe input with zero delay removes torque and closes brake
    @(posedge clk);
    sel <= 1'b1;
    wait_for(0, 1'b0, 3);
    chk("no timed stop", 1'b0, tsa);
    wait_for(1, 1'b0, 4);
    @(posedge clk);
    sel <= 1'b0;
    idle(3);
    chk("held off", 2'h0, {pe, bk});
    restart();
    // Internal ramp timed stop, with normal and fast stop laid on top
    bus(1'b1, `REG_DELAY, 32'h2, 4'hf);
    cmd(32'h46);
    wait_for(3, 1'b1, 3);
    chk("ramp with torque", 2'h3, {ramp, pe});
    cmd(32'h76);
    wait_for(0, 1'b0, 3);
    chk("stop length", 1'b1, run_cyc >= 2 * TICK - 1 && run_cyc <= 2 * TICK + 1);
    wait_for(1, 1'b0, 4);
    bus(1'b0, `REG_STATUS, 32'h0, 4'hf);
    chk("torque off status", 1'b1, got[5]);
    cmd(32'h44);
    idle(3);
    wait_for(3, 1'b0, 3);
    chk("no torque on deselect", 1'b0, pe);
    restart();
    // External braking variant, cut short by coast stop
    bus(1'b1, `REG_CONFIG, 32'h7, 4'hf);
    bus(1'b1, `REG_DELAY, 32'ha, 4'hf);
    @(posedge clk);
    xbrk <= 1'b1;
    cmd(32'h46);
    wait_for(3, 1'b1, 3);
    chk("no internal ramp", 1'b0, ramp);
    cmd(32'h4e);
    wait_for(0, 1'b0, 3);
    cmd(32'h4c);
    idle(10);
    @(posedge clk);
    xbrk <= 1'b0;
    restart();
    // Brake path fault cuts brake current; latched fault needs its own ack
    bus(1'b1, `REG_CONFIG, 32'h3, 4'hf);
    @(posedge clk);
    brk <= 1'b1;
    wait_for(1, 1'b0, 3);
    idle(3);
    bus(1'b0, `REG_STATUS, 32'h0, 4'hf);
    chk("fault status", 2'h3, {got[6], got[1]});
    brk <= 1'b0;
    idle(3);
    cmd(32'hc4);
    idle(3);
    bus(1'b0, `REG_STATUS, 32'h0, 4'hf);
    chk("latched fault cleared", 1'b0, got[6]);
    end_of_test();
  end
endmodule
